// file: include/ccsc_params.svh
// Constants of the clock-synchronized serial channel: offsets, field positions, resets, timing
// Assumes a 20-bit byte address on the register port and a 10 MHz system clock
`ifndef CCSC_PARAMS_SVH
`define CCSC_PARAMS_SVH
`define CCSC_A_CTRL 20'h401E8
`define CCSC_A_IRDA 20'h401E9
`define CCSC_A_TXD 20'h401E4
`define CCSC_A_RXD 20'h401E5
`define CCSC_A_STAT 20'h401E6
`define CCSC_A_IEN 20'h40276
`define CCSC_A_CAUSE 20'h40286
`define CCSC_A_PFS 20'h402D0
`define CCSC_B_MODE 1:0
`define CCSC_B_CLOCK_SOURCE_SELECT 2
`define CCSC_B_RECEIVE_ENABLE_BIT 6
`define CCSC_B_TRANSMIT_ENABLE_BIT 7
`define CCSC_B_IRMD 1:0
`define CCSC_IRMD_NORMAL 2'h0
`define CCSC_B_ERR 2:0
`define CCSC_B_RXFULL 3
`define CCSC_B_TXEMPTY 4
`define CCSC_B_CAUSE 5:3
`define CCSC_C_ERR 0
`define CCSC_C_RX 1
`define CCSC_C_TX 2
`define CCSC_E_OVR 0
`define CCSC_E_PAR 1
`define CCSC_E_FRM 2
`define CCSC_B_PFS 7:4
`define CCSC_P_SDI 0
`define CCSC_P_SDO 1
`define CCSC_P_SCLK 2
`define CCSC_P_RDY 3
`define CCSC_RST_BYTE 8'h00
`define CCSC_LAST_BIT 3'h7
`define CCSC_FRAME_LAST 4'h9
`define CCSC_CLK_NS 100
`define CCSC_BIT_NS 8000
`define CCSC_BIT_CYC (8'((`CCSC_BIT_NS) / (`CCSC_CLK_NS)))
`define CCSC_HALF_CYC (8'((`CCSC_BIT_NS) / (2 * (`CCSC_CLK_NS))))
`endif

// file: include/ccsc_pkg.sv
// Types of the clock-synchronized serial channel
// Assumes the constants header is included where numbers are needed
package ccsc_pkg;
  typedef logic [19:0] ccsc_addr_t;
  typedef logic [7:0] ccsc_byte_t;
  typedef enum logic [1:0] {MODE_SYNC_MASTER, MODE_SYNC_SLAVE, MODE_RSVD, MODE_ASYNC} ccsc_mode_t;
  typedef enum logic [1:0] {SY_IDLE, SY_SHIFT} ccsc_sync_st_t;
  typedef enum logic [1:0] {TX_IDLE, TX_RUN} ccsc_atx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_HALF, RX_BITS, RX_STOP} ccsc_arx_st_t;
endpackage

// file: include/ccsc_xfer_if.sv
// Word exchange between the register file and one transfer engine
// Assumes one engine per instance; all engine outputs are registered pulses or levels
`timescale 1ns/10ps
`default_nettype none
interface ccsc_xfer_if;
  logic [7:0] tx_word;
  logic tx_avail;
  logic tx_take;
  logic [7:0] rx_word;
  logic rx_done;
  logic frame_err;
  logic run_tx;
  logic run_rx;
  logic dout;
  logic rdy_n;
  modport core (output tx_word, tx_avail, run_tx, run_rx, input tx_take, rx_word, rx_done, frame_err, dout, rdy_n);
  modport engine (input tx_word, tx_avail, run_tx, run_rx, output tx_take, rx_word, rx_done, frame_err, dout, rdy_n);
endinterface
`default_nettype wire

// file: rtl/ccsc_sync_shift.sv
// Clock-synchronized slave shifter, clocked by the master's shift clock, LSB first
// Assumes pin inputs synchronous to clk_sys and run enables stable during a frame
`timescale 1ns/10ps
`default_nettype none
`include "ccsc_params.svh"
module ccsc_sync_shift (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Pins after function select
  input wire logic sclk_n,
  input wire logic sdi,
  // Word exchange
  ccsc_xfer_if.engine x
);
  import ccsc_pkg::*;
  ccsc_sync_st_t st_q, st_d;
  ccsc_byte_t sh_q, sh_d, rxw_q, rxw_d;
  logic [2:0] cnt_q, cnt_d;
  logic is_tx_q, is_tx_d, sclk_q, dout_q, dout_d, rdy_q, rdy_d, take_q, take_d, done_q, done_d;
  logic rise, fall;

  always_comb begin
    rise = !sclk_q && sclk_n;
    fall = sclk_q && !sclk_n;
    st_d = st_q;
    sh_d = sh_q;
    rxw_d = rxw_q;
    cnt_d = cnt_q;
    is_tx_d = is_tx_q;
    dout_d = dout_q;
    rdy_d = rdy_q;
    take_d = 1'b0;
    done_d = 1'b0;
    case (st_q)
      SY_IDLE: begin
        rdy_d = 1'b1;
        if (x.run_tx && x.tx_avail) begin
          take_d = 1'b1;
          sh_d = x.tx_word;
          dout_d = x.tx_word[0];
          is_tx_d = 1'b1;
          cnt_d = 3'h0;
          rdy_d = 1'b0;
          st_d = SY_SHIFT;
        end else if (x.run_rx) begin
          is_tx_d = 1'b0;
          cnt_d = 3'h0;
          rdy_d = 1'b0;
          st_d = SY_SHIFT;
        end
      end
      SY_SHIFT: begin
        if (!(is_tx_q ? x.run_tx : x.run_rx)) begin
          rdy_d = 1'b1;
          st_d = SY_IDLE;
        end else if (rise) begin
          sh_d = {sdi, sh_q[7:1]};
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == `CCSC_LAST_BIT) begin
            rdy_d = 1'b1;
            done_d = !is_tx_q;
            rxw_d = {sdi, sh_q[7:1]};
            st_d = SY_IDLE;
          end
        end else if (fall) begin
          dout_d = sh_q[0];
        end
      end
      default: st_d = SY_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q <= SY_IDLE;
      sh_q <= `CCSC_RST_BYTE;
      rxw_q <= `CCSC_RST_BYTE;
      cnt_q <= 3'h0;
      is_tx_q <= 1'b0;
      sclk_q <= 1'b1;
      dout_q <= 1'b1;
      rdy_q <= 1'b1;
      take_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      rxw_q <= rxw_d;
      cnt_q <= cnt_d;
      is_tx_q <= is_tx_d;
      sclk_q <= sclk_n;
      dout_q <= dout_d;
      rdy_q <= rdy_d;
      take_q <= take_d;
      done_q <= done_d;
    end
  end

  assign x.tx_take = take_q;
  assign x.rx_done = done_q;
  assign x.rx_word = rxw_q;
  assign x.frame_err = 1'b0;
  assign x.dout = dout_q;
  assign x.rdy_n = rdy_q;

  a_ready_on_load: assert property (@(posedge clk_sys) disable iff (reset) take_q |-> !rdy_q)
    else $error("ready not low when a word was loaded");
  a_eight_bit_word: assert property (@(posedge clk_sys) disable iff (reset) done_q |-> $past(cnt_q) == `CCSC_LAST_BIT)
    else $error("receive word completed after a wrong bit count");
endmodule
`default_nettype wire

// file: rtl/ccsc_async_frame.sv
// Asynchronous framer: start bit, eight data bits LSB first, stop bit, fixed bit time
// Assumes the line idles high and the bit time constant matches the partner
`timescale 1ns/10ps
`default_nettype none
`include "ccsc_params.svh"
module ccsc_async_frame (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Data input after function select
  input wire logic sdi,
  // Word exchange
  ccsc_xfer_if.engine x
);
  import ccsc_pkg::*;
  ccsc_atx_st_t tst_q, tst_d;
  ccsc_arx_st_t rst_q, rst_d;
  logic [9:0] frm_q, frm_d;
  logic [3:0] tbit_q, tbit_d;
  logic [7:0] tdiv_q, tdiv_d, rdiv_q, rdiv_d;
  logic [2:0] rcnt_q, rcnt_d;
  ccsc_byte_t rsh_q, rsh_d, rxw_q, rxw_d;
  logic dout_q, dout_d, take_q, take_d, done_q, done_d, ferr_q, ferr_d;

  always_comb begin
    tst_d = tst_q;
    frm_d = frm_q;
    tbit_d = tbit_q;
    tdiv_d = tdiv_q;
    dout_d = dout_q;
    take_d = 1'b0;
    case (tst_q)
      TX_IDLE: begin
        dout_d = 1'b1;
        if (x.run_tx && x.tx_avail) begin
          take_d = 1'b1;
          frm_d = {1'b1, x.tx_word, 1'b0};
          dout_d = 1'b0;
          tbit_d = 4'h0;
          tdiv_d = 8'h00;
          tst_d = TX_RUN;
        end
      end
      TX_RUN: begin
        if (tdiv_q == `CCSC_BIT_CYC - 8'h01) begin
          tdiv_d = 8'h00;
          frm_d = {1'b1, frm_q[9:1]};
          dout_d = frm_q[1];
          tbit_d = tbit_q + 4'h1;
          if (tbit_q == `CCSC_FRAME_LAST) begin
            dout_d = 1'b1;
            tst_d = TX_IDLE;
          end
        end else begin
          tdiv_d = tdiv_q + 8'h01;
        end
      end
      default: tst_d = TX_IDLE;
    endcase
  end

  // Receive side: start bit checked at mid-bit, stop bit flags a framing error
  always_comb begin
    rst_d = rst_q;
    rdiv_d = rdiv_q;
    rcnt_d = rcnt_q;
    rsh_d = rsh_q;
    rxw_d = rxw_q;
    done_d = 1'b0;
    ferr_d = 1'b0;
    case (rst_q)
      RX_IDLE: begin
        rdiv_d = 8'h00;
        if (x.run_rx && !sdi) begin
          rst_d = RX_HALF;
        end
      end
      RX_HALF: begin
        rdiv_d = rdiv_q + 8'h01;
        if (rdiv_q == `CCSC_HALF_CYC - 8'h01) begin
          rdiv_d = 8'h00;
          rcnt_d = 3'h0;
          rst_d = sdi ? RX_IDLE : RX_BITS;
        end
      end
      RX_BITS: begin
        rdiv_d = rdiv_q + 8'h01;
        if (rdiv_q == `CCSC_BIT_CYC - 8'h01) begin
          rdiv_d = 8'h00;
          rsh_d = {sdi, rsh_q[7:1]};
          rcnt_d = rcnt_q + 3'h1;
          if (rcnt_q == `CCSC_LAST_BIT) begin
            rst_d = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        rdiv_d = rdiv_q + 8'h01;
        if (rdiv_q == `CCSC_BIT_CYC - 8'h01) begin
          done_d = 1'b1;
          rxw_d = rsh_q;
          ferr_d = !sdi;
          rst_d = RX_IDLE;
        end
      end
      default: rst_d = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tst_q <= TX_IDLE;
      rst_q <= RX_IDLE;
      frm_q <= 10'h3FF;
      tbit_q <= 4'h0;
      tdiv_q <= 8'h00;
      rdiv_q <= 8'h00;
      rcnt_q <= 3'h0;
      rsh_q <= `CCSC_RST_BYTE;
      rxw_q <= `CCSC_RST_BYTE;
      dout_q <= 1'b1;
      take_q <= 1'b0;
      done_q <= 1'b0;
      ferr_q <= 1'b0;
    end else begin
      tst_q <= tst_d;
      rst_q <= rst_d;
      frm_q <= frm_d;
      tbit_q <= tbit_d;
      tdiv_q <= tdiv_d;
      rdiv_q <= rdiv_d;
      rcnt_q <= rcnt_d;
      rsh_q <= rsh_d;
      rxw_q <= rxw_d;
      dout_q <= dout_d;
      take_q <= take_d;
      done_q <= done_d;
      ferr_q <= ferr_d;
    end
  end

  assign x.tx_take = take_q;
  assign x.rx_done = done_q;
  assign x.rx_word = rxw_q;
  assign x.frame_err = ferr_q;
  assign x.dout = dout_q;
  assign x.rdy_n = 1'b1;

  sequence s_start_bit;
    !dout_q [*8];
  endsequence
  a_start_bit_out: assert property (@(posedge clk_sys) disable iff (reset) take_q |-> s_start_bit)
    else $error("start bit not driven low after a load");
endmodule
`default_nettype wire

// file: rtl/ccsc_channel.sv
// Serial channel top: register file, cause flags, pin function select, engine selection
// Assumes a single-cycle register port, pins synchronous to clk_sys, one clock domain
//
// Overview of operation
// - Sync mode shifts bits on shared clock
// - Async words carry start and stop bits
// - Slave uses data in, out, clock, ready
// - Interface mode unknown until software writes it
// - Sync slave is clocked by master clock
// - Sync mode never enables both directions
// - Writing zero clears status error flags
// - Cause flags need clearing before interrupts
// - Transmit empty cause set on shifter load
// - Requests issue only for enabled causes
// - Cause flags stay set until cleared
// - Three sources: error, receive full, transmit empty
// - Control and interface-mode registers at fixed addresses
// - Enable and cause registers at fixed addresses
// - Four select bits hand pins to channel
// - Slave drives ready low when prepared
// - Receive full cause set on buffer load
// - Sync mode flags only overrun errors
`timescale 1ns/10ps
`default_nettype none
`include "ccsc_params.svh"
module ccsc_channel (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register port
  input wire ccsc_pkg::ccsc_addr_t reg_addr,
  input wire ccsc_pkg::ccsc_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output ccsc_pkg::ccsc_byte_t reg_rdata,
  // Serial pins
  input wire logic serial_data_in_pin,
  output logic serial_data_out_pin,
  output logic serial_data_out_pin_oe,
  input wire logic shift_clock_pin_n,
  output logic ready_handshake_pin_n,
  output logic ready_handshake_pin_n_oe,
  // Interrupt requests, vectors 60, 61, 62 in this order
  output logic irq_rx_error,
  output logic irq_rx_full,
  output logic irq_tx_empty
);
  import ccsc_pkg::*;
  ccsc_byte_t ctrl_q, ctrl_d, ir_q, ir_d, txd_q, txd_d, rxd_q, rxd_d, rdata_q, rdata_d;
  logic ir_set_q, ir_set_d, tx_full_q, tx_full_d, rx_full_q, rx_full_d;
  logic [2:0] err_q, err_d, ien_q, ien_d, cause_q, cause_d, armed_q, armed_d, irq_q, irq_d, ev;
  logic [3:0] pfs_q, pfs_d;
  logic sdo_q, sdo_d, sdo_oe_q, sdo_oe_d, rdy_q, rdy_d, rdy_oe_q, rdy_oe_d;
  ccsc_mode_t mode, wmode;
  logic is_async, ch_ok, run_tx, run_rx, take, done, ferr, eng_dout, eng_rdy, sdi, sclk_n;
  logic ovr_evt, rd_rxd;
  ccsc_byte_t word;

  ccsc_xfer_if sy ();
  ccsc_xfer_if as ();

  assign sdi = pfs_q[`CCSC_P_SDI] ? serial_data_in_pin : 1'b1;
  assign sclk_n = pfs_q[`CCSC_P_SCLK] ? shift_clock_pin_n : 1'b1;

  // channel runs only when fully set up
  assign mode = ccsc_mode_t'(ctrl_q[`CCSC_B_MODE]);
  assign is_async = (mode == MODE_ASYNC);
  assign ch_ok = ir_set_q && (ir_q[`CCSC_B_IRMD] == `CCSC_IRMD_NORMAL)
    && (is_async || (mode == MODE_SYNC_SLAVE && ctrl_q[`CCSC_B_CLOCK_SOURCE_SELECT]));
  assign run_tx = ch_ok && ctrl_q[`CCSC_B_TRANSMIT_ENABLE_BIT];
  assign run_rx = ch_ok && ctrl_q[`CCSC_B_RECEIVE_ENABLE_BIT];

  assign sy.tx_word = txd_q;
  assign sy.tx_avail = tx_full_q;
  assign sy.run_tx = run_tx && !is_async;
  assign sy.run_rx = run_rx && !is_async;
  assign as.tx_word = txd_q;
  assign as.tx_avail = tx_full_q;
  assign as.run_tx = run_tx && is_async;
  assign as.run_rx = run_rx && is_async;

  assign take = is_async ? as.tx_take : sy.tx_take;
  assign done = is_async ? as.rx_done : sy.rx_done;
  assign word = is_async ? as.rx_word : sy.rx_word;
  assign ferr = is_async ? as.frame_err : sy.frame_err;
  assign eng_dout = is_async ? as.dout : sy.dout;
  assign eng_rdy = is_async ? as.rdy_n : sy.rdy_n;

  ccsc_sync_shift u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .sclk_n(sclk_n),
    .sdi(sdi),
    .x(sy.engine)
  );

  ccsc_async_frame u_async (
    .clk_sys(clk_sys),
    .reset(reset),
    .sdi(sdi),
    .x(as.engine)
  );

  always_comb begin
    wmode = ccsc_mode_t'(reg_wdata[`CCSC_B_MODE]);
    rd_rxd = reg_rd && (reg_addr == `CCSC_A_RXD);
    ctrl_d = ctrl_q;
    ir_d = ir_q;
    ir_set_d = ir_set_q;
    txd_d = txd_q;
    tx_full_d = tx_full_q;
    rxd_d = rxd_q;
    rx_full_d = rx_full_q;
    ien_d = ien_q;
    pfs_d = pfs_q;
    err_d = err_q;
    cause_d = cause_q;
    armed_d = armed_q;
    if (reg_wr) begin
      case (reg_addr)
        `CCSC_A_CTRL: begin
          ctrl_d = reg_wdata;
          if (wmode != MODE_ASYNC && reg_wdata[`CCSC_B_TRANSMIT_ENABLE_BIT]) begin
            ctrl_d[`CCSC_B_RECEIVE_ENABLE_BIT] = 1'b0;
          end
        end
        `CCSC_A_IRDA: begin
          ir_d = reg_wdata;
          ir_set_d = 1'b1;
        end
        `CCSC_A_TXD: txd_d = reg_wdata;
        `CCSC_A_STAT: err_d = err_q & reg_wdata[`CCSC_B_ERR];
        `CCSC_A_IEN: ien_d = reg_wdata[`CCSC_B_CAUSE];
        `CCSC_A_CAUSE: begin
          cause_d = cause_q & ~reg_wdata[`CCSC_B_CAUSE];
          armed_d = armed_q | reg_wdata[`CCSC_B_CAUSE];
        end
        `CCSC_A_PFS: pfs_d = reg_wdata[`CCSC_B_PFS];
        default: ;
      endcase
    end
    // New word written at the same edge as a load stays pending
    if (take) begin
      tx_full_d = 1'b0;
    end
    if (reg_wr && reg_addr == `CCSC_A_TXD) begin
      tx_full_d = 1'b1;
    end
    if (rd_rxd) begin
      rx_full_d = 1'b0;
    end
    if (done) begin
      rxd_d = word;
      rx_full_d = 1'b1;
    end
    // overrun in every mode; parity never set, framing only in async
    ovr_evt = done && rx_full_q && !rd_rxd;
    err_d[`CCSC_E_OVR] = err_d[`CCSC_E_OVR] | ovr_evt;
    err_d[`CCSC_E_FRM] = err_d[`CCSC_E_FRM] | (done && ferr);
    ev = 3'h0;
    ev[`CCSC_C_ERR] = ovr_evt || (done && ferr);
    ev[`CCSC_C_RX] = done;
    ev[`CCSC_C_TX] = take;
    cause_d = cause_d | ev;
    irq_d = cause_q & ien_q & armed_q;
    rdata_d = `CCSC_RST_BYTE;
    if (reg_rd) begin
      case (reg_addr)
        `CCSC_A_CTRL: rdata_d = ctrl_q;
        `CCSC_A_IRDA: rdata_d = ir_q;
        `CCSC_A_TXD: rdata_d = txd_q;
        `CCSC_A_RXD: rdata_d = rxd_q;
        `CCSC_A_STAT: begin
          rdata_d[`CCSC_B_ERR] = err_q;
          rdata_d[`CCSC_B_RXFULL] = rx_full_q;
          rdata_d[`CCSC_B_TXEMPTY] = !tx_full_q;
        end
        `CCSC_A_IEN: rdata_d[`CCSC_B_CAUSE] = ien_q;
        `CCSC_A_CAUSE: rdata_d[`CCSC_B_CAUSE] = cause_q;
        `CCSC_A_PFS: rdata_d[`CCSC_B_PFS] = pfs_q;
        default: rdata_d = `CCSC_RST_BYTE;
      endcase
    end
    sdo_d = pfs_q[`CCSC_P_SDO] ? eng_dout : 1'b1;
    sdo_oe_d = pfs_q[`CCSC_P_SDO] && run_tx;
    rdy_d = eng_rdy;
    rdy_oe_d = pfs_q[`CCSC_P_RDY] && ch_ok && !is_async;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_q <= `CCSC_RST_BYTE;
      ir_q <= `CCSC_RST_BYTE;
      ir_set_q <= 1'b0;
      txd_q <= `CCSC_RST_BYTE;
      tx_full_q <= 1'b0;
      rxd_q <= `CCSC_RST_BYTE;
      rx_full_q <= 1'b0;
      ien_q <= 3'h0;
      pfs_q <= 4'h0;
      err_q <= 3'h0;
      cause_q <= 3'h0;
      armed_q <= 3'h0;
      irq_q <= 3'h0;
      rdata_q <= `CCSC_RST_BYTE;
      sdo_q <= 1'b1;
      sdo_oe_q <= 1'b0;
      rdy_q <= 1'b1;
      rdy_oe_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      ir_q <= ir_d;
      ir_set_q <= ir_set_d;
      txd_q <= txd_d;
      tx_full_q <= tx_full_d;
      rxd_q <= rxd_d;
      rx_full_q <= rx_full_d;
      ien_q <= ien_d;
      pfs_q <= pfs_d;
      err_q <= err_d;
      cause_q <= cause_d;
      armed_q <= armed_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
      sdo_q <= sdo_d;
      sdo_oe_q <= sdo_oe_d;
      rdy_q <= rdy_d;
      rdy_oe_q <= rdy_oe_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign serial_data_out_pin = sdo_q;
  assign serial_data_out_pin_oe = sdo_oe_q;
  assign ready_handshake_pin_n = rdy_q;
  assign ready_handshake_pin_n_oe = rdy_oe_q;
  assign irq_rx_error = irq_q[`CCSC_C_ERR];
  assign irq_rx_full = irq_q[`CCSC_C_RX];
  assign irq_tx_empty = irq_q[`CCSC_C_TX];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_tx_empty_cause: assert property (take |=> cause_q[`CCSC_C_TX])
    else $error("transmit empty cause missed a load");
  a_rx_full_cause: assert property (done |=> cause_q[`CCSC_C_RX] && rx_full_q)
    else $error("receive full cause missed a load");
  a_irq_gated: assert property (irq_q != 3'h0 |-> ($past(ien_q) & irq_q) == irq_q)
    else $error("request raised without its enable");
  a_cause_sticky: assert property (cause_q[`CCSC_C_ERR] && !(reg_wr && reg_addr == `CCSC_A_CAUSE)
    |=> cause_q[`CCSC_C_ERR])
    else $error("cause flag dropped without a clear");
  a_dir_exclusive: assert property (!is_async |-> !(ctrl_q[`CCSC_B_TRANSMIT_ENABLE_BIT] && ctrl_q[`CCSC_B_RECEIVE_ENABLE_BIT]))
    else $error("both directions enabled in sync mode");
  a_err_clear: assert property (reg_wr && reg_addr == `CCSC_A_STAT && !reg_wdata[`CCSC_E_OVR]
    && !ovr_evt |=> !err_q[`CCSC_E_OVR])
    else $error("overrun flag survived a zero write");
  a_no_parity: assert property (!err_q[`CCSC_E_PAR]
    && !(!is_async && err_q[`CCSC_E_FRM] && $rose(err_q[`CCSC_E_FRM])))
    else $error("parity or framing flagged in sync mode");
  a_unset_irmode: assert property (!ir_set_q |-> !run_tx && !run_rx ##1 !sdo_oe_q)
    else $error("channel ran before interface mode was written");
endmodule
`default_nettype wire

// file: testbench/ccsc_sync_master.sv
// Behavioural clock-synchronized master facing the channel's slave pins
// Assumes clk_sys at 10 MHz; the bench starts each frame by calling frame
`timescale 1ns/10ps
`default_nettype none
module ccsc_sync_master (
  // Clock
  input wire logic clk_sys,
  // Slave pins as seen on the wires
  input wire logic rdy_n,
  input wire logic sdo,
  // Master pins
  output logic sclk_n,
  output logic sdi
);
  initial begin
    sclk_n = 1'b1;
    sdi = 1'b1;
  end
  // Hold is cycles in the low clock phase, hold plus one in the high phase; ok drops when ready never comes
  task automatic frame(input logic [7:0] tx, input int hold, output logic [7:0] rx, output logic ok);
    int n;
    n = 0;
    ok = 1'b1;
    rx = 8'h00;
    @(negedge clk_sys);
    while (rdy_n !== 1'b0 && n < 500) begin
      @(negedge clk_sys);
      n++;
    end
    if (rdy_n !== 1'b0) begin
      ok = 1'b0;
      return;
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      sclk_n <= 1'b0;
      sdi <= tx[i];
      repeat (hold - 1) @(posedge clk_sys);
      @(negedge clk_sys);
      rx[i] = sdo;
      @(posedge clk_sys);
      sclk_n <= 1'b1;
      repeat (hold) @(posedge clk_sys);
    end
    // Released line must not keep showing the last bit
    sdi <= ~tx[7];
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_clock_sync_serial_channel.sv
// Self-checking bench for the channel in clock-synchronized slave mode, plus one asynchronous transmit frame
// Assumes the master model and the constants header are on the include path
`timescale 1ns/10ps
`default_nettype none
`include "ccsc_params.svh"
module tb_clock_sync_serial_channel;
  import ccsc_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  ccsc_addr_t reg_addr = '0;
  ccsc_byte_t reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  ccsc_byte_t reg_rdata;
  logic sdi, sdo, sdo_oe, sclk_n, rdy_n, rdy_oe, irq_err, irq_rx, irq_tx;
  logic sdo_w, rdy_w;
  int n_fail = 0;
  int cmp_count = 0;
  always #50 clk_sys = ~clk_sys;
  // Both lines rest high through pull-ups while the channel releases them
  assign sdo_w = sdo_oe ? sdo : 1'b1;
  assign rdy_w = rdy_oe ? rdy_n : 1'b1;
  ccsc_channel i_ccsc_channel (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_data_in_pin(sdi), .serial_data_out_pin(sdo), .serial_data_out_pin_oe(sdo_oe),
    .shift_clock_pin_n(sclk_n), .ready_handshake_pin_n(rdy_n), .ready_handshake_pin_n_oe(rdy_oe),
    .irq_rx_error(irq_err), .irq_rx_full(irq_rx), .irq_tx_empty(irq_tx));
  ccsc_sync_master i_ccsc_sync_master (.clk_sys(clk_sys), .rdy_n(rdy_w), .sdo(sdo_w),
    .sclk_n(sclk_n), .sdi(sdi));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input ccsc_addr_t a, input ccsc_byte_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input ccsc_addr_t a, output ccsc_byte_t v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask
  task automatic frame_chk(input logic [7:0] tx, input int hold, input logic [7:0] exp);
    logic [7:0] v;
    logic ok;
    i_ccsc_sync_master.frame(tx, hold, v, ok);
    chk({7'h0, ok}, 8'h01);
    chk(v, exp);
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic t_reset;
    ccsc_byte_t v;
    @(negedge clk_sys);
    chk({1'b0, sdo, sdo_oe, rdy_n, rdy_oe, irq_err, irq_rx, irq_tx}, 8'h50);
    rd(20'h401E7, v);
    chk(v, 8'h00);
    wr(`CCSC_A_PFS, 8'hF0);
    wr(`CCSC_A_CTRL, 8'h45);
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({7'h0, rdy_w}, 8'h01);
    wr(`CCSC_A_CTRL, 8'h00);
  endtask
  task automatic t_setup;
    ccsc_byte_t v;
    wr(`CCSC_A_IEN, 8'h00);
    wr(`CCSC_A_CTRL, 8'h00);
    wr(`CCSC_A_IRDA, {6'h0, `CCSC_IRMD_NORMAL});
    wr(`CCSC_A_CTRL, 8'h01);
    wr(`CCSC_A_CTRL, 8'h85);
    wr(`CCSC_A_STAT, 8'h00);
    wr(`CCSC_A_CAUSE, 8'h38);
    wr(`CCSC_A_IEN, 8'h38);
    rd(`CCSC_A_CTRL, v);
    chk(v, 8'h85);
    rd(`CCSC_A_PFS, v);
    chk(v & 8'hF0, 8'hF0);
    rd(`CCSC_A_IEN, v);
    chk(v & 8'h38, 8'h38);
    chk({5'h0, irq_err, irq_rx, irq_tx}, 8'h00);
  endtask
  task automatic t_tx;
    ccsc_byte_t v;
    wr(`CCSC_A_TXD, 8'hA5);
    // Cause flag follows the load two cycles after the write
    repeat (2) @(posedge clk_sys);
    rd(`CCSC_A_CAUSE, v);
    chk(v & 8'h38, 8'h20);
    chk({7'h0, irq_tx}, 8'h01);
    frame_chk(8'h00, 4, 8'hA5);
    rd(`CCSC_A_CAUSE, v);
    chk(v & 8'h20, 8'h20);
    wr(`CCSC_A_CAUSE, 8'h20);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({7'h0, irq_tx}, 8'h00);
    wr(`CCSC_A_IEN, 8'h18);
    wr(`CCSC_A_TXD, 8'h3C);
    frame_chk(8'h00, 8, 8'h3C);
    rd(`CCSC_A_CAUSE, v);
    chk(v & 8'h20, 8'h20);
    chk({7'h0, irq_tx}, 8'h00);
    wr(`CCSC_A_CAUSE, 8'h20);
    wr(`CCSC_A_IEN, 8'h38);
  endtask
  task automatic t_both;
    ccsc_byte_t v;
    wr(`CCSC_A_CTRL, 8'h00);
    wr(`CCSC_A_CTRL, 8'hC5);
    rd(`CCSC_A_CTRL, v);
    chk(v, 8'h85);
    wr(`CCSC_A_CTRL, 8'h00);
  endtask
  task automatic t_rx;
    ccsc_byte_t v;
    wr(`CCSC_A_CTRL, 8'h45);
    frame_chk(8'h96, 4, 8'hFF);
    chk({7'h0, sdo_oe}, 8'h00);
    rd(`CCSC_A_STAT, v);
    chk(v & 8'h0F, 8'h08);
    rd(`CCSC_A_CAUSE, v);
    chk(v & 8'h38, 8'h10);
    chk({7'h0, irq_rx}, 8'h01);
    rd(`CCSC_A_RXD, v);
    chk(v, 8'h96);
    wr(`CCSC_A_CAUSE, 8'h10);
    frame_chk(8'h5A, 6, 8'hFF);
    frame_chk(8'h0F, 4, 8'hFF);
    rd(`CCSC_A_STAT, v);
    chk(v & 8'h07, 8'h01);
    chk({7'h0, irq_err}, 8'h01);
    wr(`CCSC_A_STAT, 8'h00);
    rd(`CCSC_A_STAT, v);
    chk(v & 8'h07, 8'h00);
    rd(`CCSC_A_CAUSE, v);
    chk(v & 8'h08, 8'h08);
  endtask
  task automatic t_async;
    logic [9:0] f;
    wr(`CCSC_A_CTRL, 8'h00);
    wr(`CCSC_A_CTRL, 8'h83);
    wr(`CCSC_A_TXD, 8'hC3);
    // Start bit reaches the pin two cycles after the write; sample each bit mid-way
    repeat (41) @(posedge clk_sys);
    for (int k = 0; k < 10; k++) begin
      @(negedge clk_sys);
      f[k] = sdo;
      repeat (`CCSC_BIT_NS / `CCSC_CLK_NS) @(posedge clk_sys);
    end
    chk(f[8:1], 8'hC3);
    chk({6'h0, f[9], f[0]}, 8'h02);
    wr(`CCSC_A_CTRL, 8'h00);
  endtask
  task automatic t_rst2;
    ccsc_byte_t v;
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    chk({1'b0, sdo, sdo_oe, rdy_n, rdy_oe, irq_err, irq_rx, irq_tx}, 8'h50);
    rd(`CCSC_A_CTRL, v);
    chk(v, 8'h00);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_setup();
    t_tx();
    t_both();
    t_rx();
    t_async();
    t_rst2();
    close_out();
  end
endmodule
`default_nettype wire
